// ---- hdl/i2c_master_pkg.sv ----
// Constants shared by the two-wire master sequencer: register map,
// field positions, reset values and state codes.
// Assumes a 32-bit APB master and an open-drain SDA/SCL pad outside.
package i2c_master_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CONTROL_TWO = 8'h00;
  localparam logic [7:0] OFS_PORT_STATUS = 8'h04;
  localparam logic [7:0] OFS_DATA_BUFFER = 8'h08;
  localparam logic [7:0] OFS_RATE_RELOAD = 8'h0c;
  localparam logic [7:0] OFS_EVENT_FLAGS = 8'h10;

  // control_two fields
  localparam int CT_START_EN = 0;
  localparam int CT_RESTART_EN = 1;
  localparam int CT_RECEIVE_EN = 3;
  localparam int CT_ACK_SEQ_EN = 4;
  localparam int CT_ACK_DATA = 5;
  localparam int CT_ACK_STATUS = 6;

  // port_status fields
  localparam int PS_BUFFER_FULL = 0;
  localparam int PS_START_SEEN = 3;
  localparam int PS_RX_OVERFLOW = 6;
  localparam int PS_WRITE_COLL = 7;

  // event_flags fields
  localparam int EF_SERIAL_EVENT = 0;
  localparam int EF_BUS_COLL = 1;

  // Reset values
  localparam logic [6:0] RATE_RELOAD_RST = 7'h00;
  localparam logic [7:0] DATA_BUFFER_RST = 8'h00;
  localparam logic ACK_STATUS_RST = 1'b0;

  // Bit counts of one byte on the wire
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;

  typedef enum logic [10:0] {
    ST_IDLE = 11'h001,
    ST_START_WAIT = 11'h002,
    ST_START_HOLD = 11'h004,
    ST_RS_PULL = 11'h008,
    ST_RS_SDA = 11'h010,
    ST_RS_RISE = 11'h020,
    ST_RS_HIGH = 11'h040,
    ST_RS_HOLD = 11'h080,
    ST_BIT_LOW = 11'h100,
    ST_BIT_RISE = 11'h200,
    ST_BIT_HIGH = 11'h400
  } seq_state_e;

endpackage

// ---- hdl/i2c_master_sequencer.sv ----
// Two-wire bus master sequencer with an APB register file: Start,
// Repeated Start, byte transmit with acknowledge sampling, byte receive.
// Assumes open-drain pads: a high enable pulls the line low, the pad
// returns the wire level on sda_i / scl_i asynchronously.
`timescale 1ns/100ps

// Behaviour
// - Start with both lines high reloads generator from reload bits 6:0.
// - Lines still high at expiry: pull SDA low, set start_seen.
// - Count one more period, clear start_enable, stop, keep SDA low.
// - Low lines at start or early SCL low: collision flag, idle.
// - Buffer write during Start or Repeated Start ignored, write_collision.
// - Low five control bits ignored until Start sequences complete.
// - restart_enable only acts when the port is idle.
// - Restart pulls SCL low, then loads bits 5:0, SDA high a period.
// - SDA high: release SCL, reload 6:0, both high, then SDA low.
// - SDA low sets start_seen, reloads 6:0; expiry clears restart_enable, sets event flag.
// - Restart collision: SDA low as SCL rises, or SCL low early.
// - Buffer write sets buffer_full, shifts eight bits, low then high.
// - Eighth clock falling clears buffer_full and releases SDA.
// - Ninth clock falling samples SDA into ack_status.
// - After ninth clock set event flag, stop, SCL low.
// - Buffer write while shifting discarded; write_collision cleared by software.
// - receive_enable only acts when the port is idle.
// - Receiving toggles SCL each rollover, shifts SDA in each clock.
// - Eighth received clock: clear enable, copy, set flags, stop low.
// - Reading data_buffer in receive operation clears buffer_full.
// - Byte received while buffer_full set raises receive_overflow.
// - Generator counts down twice per instruction cycle; expiry is half bit_period.
// - Released SCL holds generator until SCL high, then reload 6:0.
module i2c_master_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [i2c_master_pkg::ADDR_W-1:0] paddr,
  input wire logic [i2c_master_pkg::DATA_W-1:0] pwdata,
  output logic [i2c_master_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe
);

  i2c_master_pkg::seq_state_e state_q;
  logic [6:0] rate_q;
  logic [1:0] phase_q;
  logic sda_drv_q;
  logic scl_drv_q;
  logic [7:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic rx_mode_q;
  logic sda_meta_q;
  logic sda_s_q;
  logic scl_meta_q;
  logic scl_s_q;
  logic ev_start_q;
  logic ev_seq_end_q;
  logic ev_coll_q;
  logic ev_bf_clr_q;
  logic ev_rx_done_q;
  logic ev_tx_done_q;
  logic ev_ack_val_q;
  logic start_en_q;
  logic restart_en_q;
  logic receive_en_q;
  logic ack_seq_en_q;
  logic ack_data_q;
  logic ack_status_q;
  logic buffer_full_q;
  logic start_seen_q;
  logic rx_overflow_q;
  logic write_coll_q;
  logic serial_event_q;
  logic bus_coll_q;
  logic [7:0] data_buffer_q;
  logic [6:0] rate_reload_q;
  logic [31:0] prdata_q;
  logic idle;
  logic tick;
  logic expire;
  logic wr_acc;
  logic rd_acc;
  logic wr_ctrl;
  logic wr_buf;
  logic go_start;
  logic go_restart;
  logic go_rx;
  logic go_tx;
  logic mapped;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == i2c_master_pkg::OFS_CONTROL_TWO) ||
                (a == i2c_master_pkg::OFS_PORT_STATUS) ||
                (a == i2c_master_pkg::OFS_DATA_BUFFER) ||
                (a == i2c_master_pkg::OFS_RATE_RELOAD) ||
                (a == i2c_master_pkg::OFS_EVENT_FLAGS);
  endfunction

  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  assign sda_oe = sda_drv_q;
  assign scl_oe = scl_drv_q;
  assign pready = 1'b1;
  assign mapped = is_mapped(paddr);
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_q;

  assign idle = (state_q == i2c_master_pkg::ST_IDLE);
  assign wr_acc = psel && penable && pwrite && mapped;
  assign rd_acc = psel && penable && !pwrite && mapped;
  assign wr_ctrl = wr_acc && (paddr == i2c_master_pkg::OFS_CONTROL_TWO);
  assign wr_buf = wr_acc && (paddr == i2c_master_pkg::OFS_DATA_BUFFER);
  assign go_start = wr_ctrl && idle && pwdata[i2c_master_pkg::CT_START_EN];
  assign go_restart = wr_ctrl && idle &&
                      !pwdata[i2c_master_pkg::CT_START_EN] &&
                      pwdata[i2c_master_pkg::CT_RESTART_EN];
  assign go_rx = wr_ctrl && idle &&
                 !pwdata[i2c_master_pkg::CT_START_EN] &&
                 !pwdata[i2c_master_pkg::CT_RESTART_EN] &&
                 pwdata[i2c_master_pkg::CT_RECEIVE_EN];
  assign go_tx = wr_buf && idle;

  assign tick = phase_q[0];
  assign expire = tick && (rate_q == 7'h00);

  // Pad inputs pass two flip-flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sda_meta_q <= 1'b1;
      sda_s_q <= 1'b1;
      scl_meta_q <= 1'b1;
      scl_s_q <= 1'b1;
    end
    else
    begin
      sda_meta_q <= sda_i;
      sda_s_q <= sda_meta_q;
      scl_meta_q <= scl_i;
      scl_s_q <= scl_meta_q;
    end
  end

  // Instruction-cycle phase counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase_q <= 2'h0;
    else
      phase_q <= phase_q + 2'h1;
  end

  // Sequencer: state, rate generator, line drivers, shifter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= i2c_master_pkg::ST_IDLE;
      rate_q <= 7'h00;
      sda_drv_q <= 1'b0;
      scl_drv_q <= 1'b0;
      shift_q <= 8'h00;
      bit_cnt_q <= 4'h0;
      rx_mode_q <= 1'b0;
      ev_start_q <= 1'b0;
      ev_seq_end_q <= 1'b0;
      ev_coll_q <= 1'b0;
      ev_bf_clr_q <= 1'b0;
      ev_rx_done_q <= 1'b0;
      ev_tx_done_q <= 1'b0;
      ev_ack_val_q <= 1'b0;
    end
    else
    begin
      ev_start_q <= 1'b0;
      ev_seq_end_q <= 1'b0;
      ev_coll_q <= 1'b0;
      ev_bf_clr_q <= 1'b0;
      ev_rx_done_q <= 1'b0;
      ev_tx_done_q <= 1'b0;
      if (tick && rate_q != 7'h00)
        rate_q <= rate_q - 7'h01;
      case (state_q)
        i2c_master_pkg::ST_IDLE:
        begin
          if (go_start)
          begin
            if (sda_s_q && scl_s_q)
            begin
              rate_q <= rate_reload_q;
              state_q <= i2c_master_pkg::ST_START_WAIT;
            end
            else
            begin
              ev_coll_q <= 1'b1;
            end
          end
          else if (go_restart)
          begin
            scl_drv_q <= 1'b1;
            state_q <= i2c_master_pkg::ST_RS_PULL;
          end
          else if (go_rx)
          begin
            scl_drv_q <= 1'b1;
            rate_q <= rate_reload_q;
            bit_cnt_q <= 4'h0;
            rx_mode_q <= 1'b1;
            state_q <= i2c_master_pkg::ST_BIT_LOW;
          end
          else if (go_tx)
          begin
            shift_q <= pwdata[7:0];
            scl_drv_q <= 1'b1;
            rate_q <= rate_reload_q;
            bit_cnt_q <= 4'h0;
            rx_mode_q <= 1'b0;
            state_q <= i2c_master_pkg::ST_BIT_LOW;
          end
        end
        i2c_master_pkg::ST_START_WAIT:
        begin
          if (!scl_s_q)
          begin
            ev_coll_q <= 1'b1;
            state_q <= i2c_master_pkg::ST_IDLE;
          end
          else if (expire)
          begin
            if (sda_s_q)
            begin
              sda_drv_q <= 1'b1;
              ev_start_q <= 1'b1;
              rate_q <= rate_reload_q;
              state_q <= i2c_master_pkg::ST_START_HOLD;
            end
            else
            begin
              ev_coll_q <= 1'b1;
              state_q <= i2c_master_pkg::ST_IDLE;
            end
          end
        end
        i2c_master_pkg::ST_START_HOLD:
        begin
          if (expire)
          begin
            ev_seq_end_q <= 1'b1;
            state_q <= i2c_master_pkg::ST_IDLE;
          end
        end
        i2c_master_pkg::ST_RS_PULL:
        begin
          if (!scl_s_q)
          begin
            rate_q <= {1'b0, rate_reload_q[5:0]};
            sda_drv_q <= 1'b0;
            state_q <= i2c_master_pkg::ST_RS_SDA;
          end
        end
        i2c_master_pkg::ST_RS_SDA:
        begin
          if (expire)
          begin
            if (sda_s_q)
            begin
              scl_drv_q <= 1'b0;
              state_q <= i2c_master_pkg::ST_RS_RISE;
            end
            else
            begin
              scl_drv_q <= 1'b0;
              ev_coll_q <= 1'b1;
              state_q <= i2c_master_pkg::ST_IDLE;
            end
          end
        end
        i2c_master_pkg::ST_RS_RISE:
        begin
          if (scl_s_q)
          begin
            if (!sda_s_q)
            begin
              ev_coll_q <= 1'b1;
              state_q <= i2c_master_pkg::ST_IDLE;
            end
            else
            begin
              rate_q <= rate_reload_q;
              state_q <= i2c_master_pkg::ST_RS_HIGH;
            end
          end
        end
        i2c_master_pkg::ST_RS_HIGH:
        begin
          if (!scl_s_q)
          begin
            ev_coll_q <= 1'b1;
            state_q <= i2c_master_pkg::ST_IDLE;
          end
          else if (expire)
          begin
            sda_drv_q <= 1'b1;
            ev_start_q <= 1'b1;
            rate_q <= rate_reload_q;
            state_q <= i2c_master_pkg::ST_RS_HOLD;
          end
        end
        i2c_master_pkg::ST_RS_HOLD:
        begin
          if (expire)
          begin
            ev_seq_end_q <= 1'b1;
            state_q <= i2c_master_pkg::ST_IDLE;
          end
        end
        i2c_master_pkg::ST_BIT_LOW:
        begin
          // SDA moves one cycle after SCL is pulled low
          sda_drv_q <= !rx_mode_q && !shift_q[7] &&
                       (bit_cnt_q != i2c_master_pkg::ACK_BIT);
          if (expire)
          begin
            scl_drv_q <= 1'b0;
            state_q <= i2c_master_pkg::ST_BIT_RISE;
          end
        end
        i2c_master_pkg::ST_BIT_RISE:
        begin
          if (scl_s_q)
          begin
            rate_q <= rate_reload_q;
            if (rx_mode_q)
              shift_q <= {shift_q[6:0], sda_s_q};
            state_q <= i2c_master_pkg::ST_BIT_HIGH;
          end
        end
        i2c_master_pkg::ST_BIT_HIGH:
        begin
          if (expire)
          begin
            scl_drv_q <= 1'b1;
            if (rx_mode_q)
            begin
              if (bit_cnt_q == i2c_master_pkg::LAST_DATA_BIT)
              begin
                ev_rx_done_q <= 1'b1;
                state_q <= i2c_master_pkg::ST_IDLE;
              end
              else
              begin
                bit_cnt_q <= bit_cnt_q + 4'h1;
                rate_q <= rate_reload_q;
                state_q <= i2c_master_pkg::ST_BIT_LOW;
              end
            end
            else if (bit_cnt_q == i2c_master_pkg::ACK_BIT)
            begin
              ev_ack_val_q <= sda_s_q;
              ev_tx_done_q <= 1'b1;
              state_q <= i2c_master_pkg::ST_IDLE;
            end
            else if (bit_cnt_q == i2c_master_pkg::LAST_DATA_BIT)
            begin
              // release SDA for slave in the next low phase
              ev_bf_clr_q <= 1'b1;
              bit_cnt_q <= i2c_master_pkg::ACK_BIT;
              rate_q <= rate_reload_q;
              state_q <= i2c_master_pkg::ST_BIT_LOW;
            end
            else
            begin
              shift_q <= {shift_q[6:0], 1'b0};
              bit_cnt_q <= bit_cnt_q + 4'h1;
              rate_q <= rate_reload_q;
              state_q <= i2c_master_pkg::ST_BIT_LOW;
            end
          end
        end
        default:
        begin
          state_q <= i2c_master_pkg::ST_IDLE;
        end
      endcase
      if (ev_coll_q)
      begin
        sda_drv_q <= 1'b0;
        scl_drv_q <= 1'b0;
      end
    end
  end

  // Control bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_en_q <= 1'b0;
      restart_en_q <= 1'b0;
      receive_en_q <= 1'b0;
      ack_seq_en_q <= 1'b0;
      ack_data_q <= 1'b0;
      ack_status_q <= i2c_master_pkg::ACK_STATUS_RST;
    end
    else
    begin
      if (wr_ctrl)
        ack_data_q <= pwdata[i2c_master_pkg::CT_ACK_DATA];
      if (go_start)
        start_en_q <= 1'b1;
      else if (ev_seq_end_q || ev_coll_q)
        start_en_q <= 1'b0;
      if (go_restart)
        restart_en_q <= 1'b1;
      else if (ev_seq_end_q || ev_coll_q)
        restart_en_q <= 1'b0;
      if (go_rx)
        receive_en_q <= 1'b1;
      else if (ev_rx_done_q)
        receive_en_q <= 1'b0;
      if (wr_ctrl && idle)
        ack_seq_en_q <= pwdata[i2c_master_pkg::CT_ACK_SEQ_EN];
      if (ev_tx_done_q)
        ack_status_q <= ev_ack_val_q;
    end
  end

  // Status bits, data buffer and rate reload
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      buffer_full_q <= 1'b0;
      start_seen_q <= 1'b0;
      rx_overflow_q <= 1'b0;
      write_coll_q <= 1'b0;
      serial_event_q <= 1'b0;
      bus_coll_q <= 1'b0;
      data_buffer_q <= i2c_master_pkg::DATA_BUFFER_RST;
      rate_reload_q <= i2c_master_pkg::RATE_RELOAD_RST;
    end
    else
    begin
      if (wr_acc && paddr == i2c_master_pkg::OFS_RATE_RELOAD)
        rate_reload_q <= pwdata[6:0];
      if (go_tx)
        data_buffer_q <= pwdata[7:0];
      else if (ev_rx_done_q)
        data_buffer_q <= shift_q;
      if (go_tx || ev_rx_done_q)
        buffer_full_q <= 1'b1;
      else if (ev_bf_clr_q || ev_coll_q)
        buffer_full_q <= 1'b0;
      else if (rd_acc && rx_mode_q &&
               paddr == i2c_master_pkg::OFS_DATA_BUFFER)
        buffer_full_q <= 1'b0;
      if (ev_start_q)
        start_seen_q <= 1'b1;
      else if (ev_coll_q)
        start_seen_q <= 1'b0;
      if (ev_rx_done_q && buffer_full_q)
        rx_overflow_q <= 1'b1;
      else if (wr_acc && paddr == i2c_master_pkg::OFS_PORT_STATUS)
        rx_overflow_q <= pwdata[i2c_master_pkg::PS_RX_OVERFLOW];
      if (wr_buf && !idle)
        write_coll_q <= 1'b1;
      else if (wr_acc && paddr == i2c_master_pkg::OFS_PORT_STATUS)
        write_coll_q <= pwdata[i2c_master_pkg::PS_WRITE_COLL];
      if (ev_seq_end_q || ev_tx_done_q || ev_rx_done_q)
        serial_event_q <= 1'b1;
      else if (wr_acc && paddr == i2c_master_pkg::OFS_EVENT_FLAGS)
        serial_event_q <= pwdata[i2c_master_pkg::EF_SERIAL_EVENT];
      if (ev_coll_q)
        bus_coll_q <= 1'b1;
      else if (wr_acc && paddr == i2c_master_pkg::OFS_EVENT_FLAGS)
        bus_coll_q <= pwdata[i2c_master_pkg::EF_BUS_COLL];
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        i2c_master_pkg::OFS_CONTROL_TWO:
          prdata_q <= {25'h0, ack_status_q, ack_data_q, ack_seq_en_q,
                       receive_en_q, 1'b0, restart_en_q, start_en_q};
        i2c_master_pkg::OFS_PORT_STATUS:
          prdata_q <= {24'h0, write_coll_q, rx_overflow_q, 2'h0,
                       start_seen_q, 2'h0, buffer_full_q};
        i2c_master_pkg::OFS_DATA_BUFFER:
          prdata_q <= {24'h0, data_buffer_q};
        i2c_master_pkg::OFS_RATE_RELOAD:
          prdata_q <= {25'h0, rate_reload_q};
        i2c_master_pkg::OFS_EVENT_FLAGS:
          prdata_q <= {30'h0, bus_coll_q, serial_event_q};
        default:
          prdata_q <= 32'h0000_0000;
      endcase
    end
  end

endmodule // i2c_master_sequencer

// ---- tb/i2c_master_sequencer_sva.sv ----
// Port checker for the two-wire master sequencer.
// Bound to every sequencer instance; sees its ports only.
`timescale 1ns/100ps
module i2c_master_sequencer_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [i2c_master_pkg::ADDR_W-1:0] paddr,
  input wire logic [i2c_master_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_i,
  input wire logic sda_oe,
  input wire logic scl_oe
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_ready;
    psel && penable |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("access not answered");
  property p_slverr;
    pslverr |-> psel && penable &&
      (paddr[1:0] != 2'h0 || paddr > i2c_master_pkg::OFS_EVENT_FLAGS);
  endproperty
  a_slverr: assert property (p_slverr) else $error("stray slave error");
  property p_unmapped;
    psel && !penable && !pwrite && paddr > i2c_master_pkg::OFS_EVENT_FLAGS
      |=> prdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_ct_rsv;
    psel && !penable && !pwrite && paddr == i2c_master_pkg::OFS_CONTROL_TWO
      |=> prdata[31:7] == 25'h0 && !prdata[2];
  endproperty
  a_ct_rsv: assert property (p_ct_rsv) else $error("reserved bits set");
  property p_rst;
    $rose(presetn) |-> !sda_oe && !scl_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("lines driven at reset");
  property p_start;
    $rose(sda_oe) && !scl_oe |-> scl_i && $past(scl_i);
  endproperty
  a_start: assert property (p_start) else $error("start without SCL high");
  property p_sda_fall;
    $fell(sda_oe) |-> scl_oe;
  endproperty
  a_sda_fall: assert property (p_sda_fall) else $error("SDA freed, SCL high");
  property p_stretch;
    $rose(scl_oe) |-> $past(scl_i, 3);
  endproperty
  a_stretch: assert property (p_stretch) else $error("high phase cut");
  property p_low_min;
    $rose(scl_oe) |=> scl_oe;
  endproperty
  a_low_min: assert property (p_low_min) else $error("SCL low too short");

  cover property ($rose(sda_oe) && !scl_oe);
  cover property (pslverr);
  cover property ($rose(scl_oe));
endmodule // i2c_master_sequencer_sva

bind i2c_master_sequencer i2c_master_sequencer_sva u_sva (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .scl_i(scl_i), .sda_oe(sda_oe), .scl_oe(scl_oe));

// ---- tb/i2c_master_sequencer_tb.sv ----
// Self-checking bench for the two-wire master sequencer.
// APB driven from the bench; a slave model sits on pulled-up wires.
`timescale 1ns/100ps
module i2c_master_sequencer_tb;
  localparam logic [7:0] CT = i2c_master_pkg::OFS_CONTROL_TWO;
  localparam logic [7:0] PS = i2c_master_pkg::OFS_PORT_STATUS;
  localparam logic [7:0] DB = i2c_master_pkg::OFS_DATA_BUFFER;
  localparam logic [7:0] EF = i2c_master_pkg::OFS_EVENT_FLAGS;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r, f;
  logic pready, pslverr, err, sda_o, sda_oe, scl_o, scl_oe;
  logic s_sda_oe, s_scl_oe;
  logic rd = 1'b0;
  logic ack_en = 1'b1;
  logic stretch = 1'b0;
  logic [7:0] tx = 8'h00;
  logic [7:0] rx, b;
  logic [7:0] exp_q[$];
  wire sda = !(sda_oe || s_sda_oe);
  wire scl = !(scl_oe || s_scl_oe);
  int seed = 24;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;

  always #5 pclk = ~pclk;

  i2c_master_sequencer uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe));
  i2c_slave_model peer (.scl(scl), .sda(sda), .rd(rd), .ack_en(ack_en),
    .stretch(stretch), .tx(tx), .rx(rx), .sda_oe(s_sda_oe),
    .scl_oe(s_scl_oe));

  task complete_run;
    if (mismatches == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(r & m, e);
  endtask
  // Poll event flags until one is raised, then clear them
  task wait_ev;
    int i;
    i = 0;
    r = 32'h0;
    while (r[1:0] == 2'b00 && i < 400)
    begin
      apb(1'b0, EF, 32'h0);
      i++;
    end
    f = r;
    apb(1'b1, EF, 32'h0);
  endtask

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      mismatches++;
      complete_run;
    end
  end

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k <= 16; k += 4)
      rdchk(k[7:0], 32'hffffffff, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk(r, 32'h0);
    chk(err, 1'b1);
    chk({sda_o, scl_o}, 2'b00);
    apb(1'b1, i2c_master_pkg::OFS_RATE_RELOAD, 32'h3);
    // Start with a buffer write and a receive issued during it, both ignored
    apb(1'b1, CT, 32'h1);
    apb(1'b1, DB, 32'h5a);
    apb(1'b1, CT, 32'h8);
    wait_ev;
    chk(f[1:0], 2'b01);
    rdchk(PS, 32'h89, 32'h88);
    rdchk(CT, 32'h1f, 32'h0);
    rdchk(DB, 32'hff, 32'h0);
    chk({sda, scl}, 2'b01);
    apb(1'b1, PS, 32'h0);
    rdchk(PS, 32'h80, 32'h0);
    // Acknowledged byte, then stretched unacknowledged byte
    for (int k = 0; k < 2; k++)
    begin
      b = 8'($random(seed)) & 8'hfe;
      ack_en = (k == 0);
      stretch = (k == 1);
      exp_q.push_back(b);
      apb(1'b1, DB, {24'h0, b});
      rdchk(PS, 32'h1, 32'h1);
      apb(1'b1, DB, {24'h0, ~b});
      apb(1'b1, CT, 32'h8);
      wait_ev;
      chk(rx, exp_q.pop_front());
      rdchk(PS, 32'h81, 32'h80);
      rdchk(CT, 32'h48, k ? 32'h40 : 32'h0);
      chk(scl, 1'b0);
      apb(1'b1, PS, 32'h0);
    end
    stretch = 1'b0;
    ack_en = 1'b1;
    apb(1'b1, CT, 32'h2);
    wait_ev;
    chk(f[1:0], 2'b01);
    rdchk(CT, 32'h1f, 32'h0);
    rdchk(PS, 32'h8, 32'h8);
    chk({sda, scl}, 2'b01);
    b = 8'($random(seed)) | 8'h01;
    apb(1'b1, DB, {24'h0, b});
    wait_ev;
    chk(rx, b);
    rd = 1'b1;
    // Two receptions, the second while the buffer is still full
    for (int k = 0; k < 2; k++)
    begin
      tx = 8'($random(seed));
      exp_q.push_back(tx);
      apb(1'b1, CT, 32'h8);
      wait_ev;
      chk(f[1:0], 2'b01);
      rdchk(CT, 32'h8, 32'h0);
      rdchk(PS, 32'h41, k ? 32'h41 : 32'h1);
      chk(scl, 1'b0);
    end
    rdchk(DB, 32'hff, {24'h0, exp_q[1]});
    rdchk(PS, 32'h1, 32'h0);
    apb(1'b1, CT, 32'h30);
    rdchk(CT, 32'h38, 32'h30);
    // Start while the port still holds SCL low
    rd = 1'b0;
    apb(1'b1, CT, 32'h1);
    wait_ev;
    chk(f[1:0], 2'b10);
    rdchk(CT, 32'h1, 32'h0);
    chk({sda, scl}, 2'b11);
    complete_run;
  end
endmodule // i2c_master_sequencer_tb

// ---- tb/i2c_slave_model.sv ----
// Behavioural slave on the two-wire bus: acknowledges, serves read
// bytes MSB first, may stretch SCL. Wires are pulled up outside.
`timescale 1ns/100ps
module i2c_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic rd,
  input wire logic ack_en,
  input wire logic stretch,
  input wire logic [7:0] tx,
  output logic [7:0] rx,
  output logic sda_oe,
  output logic scl_oe
);
  int n = 0;
  initial
  begin
    rx = 8'h00;
    sda_oe = 1'b0;
    scl_oe = 1'b0;
  end
  // Start or repeated start restarts the bit count
  always @(negedge sda)
    if (scl)
      n = 0;
  always @(posedge scl)
  begin
    if (n < 8)
      rx = {rx[6:0], sda};
    n = n + 1;
  end
  // Data only changes while SCL is low
  always @(negedge scl or rd or tx)
  begin
    if (!scl && n == (rd ? 8 : 9))
      n = 0;
    sda_oe = rd ? (n < 8 && !tx[7 - n]) : (ack_en && n == 8);
  end
  always @(negedge scl)
    if (stretch)
    begin
      scl_oe = 1'b1;
      #300;
      scl_oe = 1'b0;
    end
endmodule // i2c_slave_model
